// ### verilog/aicf_regs.svh
// Register offsets, field positions, reset values and timing counts of the channel block
`ifndef AICF_REGS_SVH
`define AICF_REGS_SVH

`define AICF_OFF_CTRL 8'h00
`define AICF_OFF_ALM_EN 8'h04
`define AICF_OFF_FILTER 8'h08
`define AICF_OFF_SIG_LO 8'h0C
`define AICF_OFF_SIG_HI 8'h10
`define AICF_OFF_ENG_LO 8'h14
`define AICF_OFF_ENG_HI 8'h18
`define AICF_OFF_UNLATCH 8'h1C
`define AICF_OFF_ALM_STAT 8'h20
`define AICF_OFF_VALUE 8'h24
`define AICF_OFF_IRQ_STAT 8'h28
`define AICF_OFF_IRQ_EN 8'h2C
`define AICF_OFF_IRQ_CLR 8'h30

`define AICF_CTRL_W 5
`define AICF_ALM_W 5
`define AICF_IRQ_W 7
`define AICF_IRQ_OPEN_WIRE 5
`define AICF_IRQ_VALUE 6

`define AICF_CTRL_RST 5'h01
`define AICF_FILTER_RST 16'h0000
`define AICF_SIG_LO_RST 32'h0000_0000
`define AICF_SIG_HI_RST 32'h0000_4E20
`define AICF_ENG_LO_RST 32'h0000_0000
`define AICF_ENG_HI_RST 32'h0000_4E20

`define AICF_PCLK_PERIOD_NS 100
`define AICF_FILTER_TICK_NS 1000000
`define AICF_FILTER_TICK_CYCLES (`AICF_FILTER_TICK_NS / `AICF_PCLK_PERIOD_NS)

`endif

// ### verilog/aicf_pkg.sv
// Types shared by the channel conditioning block
package aicf_pkg;

   typedef struct packed {
      logic off;
      logic open_wire_en;
      logic rate_latch;
      logic proc_latch;
      logic alarm_mask;
   } aicf_ctrl_type;

   // Bit 0 low-low, 1 low, 2 high, 3 high-high, 4 rate
   typedef logic [4:0] aicf_alarm_type;

   typedef struct packed {
      logic valid;
      logic signed [31:0] data;
   } aicf_sample_type;

   typedef struct packed {
      logic signed [31:0] sig_lo;
      logic signed [31:0] sig_hi;
      logic signed [31:0] eng_lo;
      logic signed [31:0] eng_hi;
   } aicf_points_type;

endpackage

// ### verilog/aicf_lag_filter.sv
// First-order lag filter with a time constant in milliseconds
`timescale 1ns/1ps
module aicf_lag_filter
   import aicf_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire aicf_sample_type smp, // Raw sample
   input wire logic [15:0] tau_ms, // Time constant, zero bypasses
   input wire logic ms_tick, // One-cycle pulse each millisecond
   output aicf_sample_type filt // Filtered sample
);
   logic signed [31:0] x_r, x_nxt;
   aicf_sample_type filt_r, filt_nxt;
   logic signed [32:0] diff;
   logic signed [32:0] step;
   logic [16:0] tau_p1;

   always_comb begin
      x_nxt = smp.valid ? smp.data : x_r;
      tau_p1 = {1'b0, tau_ms} + 17'h00001;
      diff = {x_r[31], x_r} - {filt_r.data[31], filt_r.data};
      step = diff / $signed({16'h0000, tau_p1});
      filt_nxt = filt_r;
      filt_nxt.valid = 1'b0;
      if (tau_ms == 16'h0000) begin
         if (smp.valid) begin
            filt_nxt.data = smp.data;
            filt_nxt.valid = 1'b1;
         end
      end else if (ms_tick) begin
         filt_nxt.data = filt_r.data + step[31:0];
         filt_nxt.valid = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_r <= 32'h0000_0000;
         filt_r <= '0;
      end else begin
         x_r <= x_nxt;
         filt_r <= filt_nxt;
      end
   end

   assign filt = filt_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_filter_bypass: assert property (
      (tau_ms == 16'h0000 && smp.valid) |=> (filt_r.valid && filt_r.data == $past(smp.data)))
      else $error("bypassed filter did not pass the sample");
   chk_filter_tick: assert property (
      (tau_ms != 16'h0000 && !ms_tick) |=> !filt_r.valid)
      else $error("lag filter updated off the millisecond tick");
endmodule

// ### verilog/aicf_channel.sv
// Analog channel configuration, alarm gating, filtering and scaling with an APB slave
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "aicf_regs.svh"

// Behaviour
// - Mask set suppresses every channel alarm
// - Alarm needs mask clear and own enable
// - Process alarms hold until unlatched when latching
// - Rate alarm holds until unlatched when latching
// - Open-wire diagnostic runs only when enabled
// - Disabled channel: indicator off, fault set
// - Zero filter bypasses; else lag in ms
// - Low output point is value at low
module aicf_channel
   import aicf_pkg::*;
#(
   parameter int MS_CYCLES = `AICF_FILTER_TICK_CYCLES
)
(
   input wire logic pclk, // Clock, 10 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire aicf_sample_type sample_in, // Converted input sample
   input wire logic [3:0] process_cond, // Process alarm conditions
   input wire logic rate_cond, // Rate alarm condition
   input wire logic open_wire_detect, // Front-end open-wire result
   output aicf_sample_type scaled_out, // Scaled engineering value
   output aicf_alarm_type alarm_out, // Active alarms
   output logic chan_fault, // Channel fault flag
   output logic status_led_on, // Channel status indicator
   output logic open_wire_test_en, // Runs the open-wire diagnostic
   output logic irq // Interrupt, active high level
);
   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   aicf_ctrl_type ctrl_r, ctrl_nxt;
   aicf_alarm_type alm_en_r, alm_en_nxt;
   logic [15:0] filter_r, filter_nxt;
   aicf_points_type pts_r, pts_nxt;
   logic [`AICF_IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   aicf_alarm_type alarm_r, alarm_nxt, unlatch_w;
   logic [`AICF_IRQ_W-1:0] irq_clr_w;
   logic wr_go;
   aicf_sample_type scaled_r, scaled_nxt;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'b00) && (a <= `AICF_OFF_IRQ_CLR);
   endfunction

   always_comb begin
      wr_go = psel && penable && pready_r && pwrite;
      pready_nxt = psel && !penable && !pready_r;
      pslverr_nxt = pready_nxt && !is_mapped(paddr);
      prdata_nxt = 32'h0000_0000;
      if (pready_nxt && !pwrite) begin
         unique case (paddr)
            `AICF_OFF_CTRL: prdata_nxt = {27'h0000000, ctrl_r};
            `AICF_OFF_ALM_EN: prdata_nxt = {27'h0000000, alm_en_r};
            `AICF_OFF_FILTER: prdata_nxt = {16'h0000, filter_r};
            `AICF_OFF_SIG_LO: prdata_nxt = pts_r.sig_lo;
            `AICF_OFF_SIG_HI: prdata_nxt = pts_r.sig_hi;
            `AICF_OFF_ENG_LO: prdata_nxt = pts_r.eng_lo;
            `AICF_OFF_ENG_HI: prdata_nxt = pts_r.eng_hi;
            `AICF_OFF_ALM_STAT: prdata_nxt = {27'h0000000, alarm_r};
            `AICF_OFF_VALUE: prdata_nxt = scaled_r.data;
            `AICF_OFF_IRQ_STAT: prdata_nxt = {25'h0000000, irq_stat_r};
            `AICF_OFF_IRQ_EN: prdata_nxt = {25'h0000000, irq_en_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      ctrl_nxt = ctrl_r;
      alm_en_nxt = alm_en_r;
      filter_nxt = filter_r;
      pts_nxt = pts_r;
      irq_en_nxt = irq_en_r;
      unlatch_w = '0;
      irq_clr_w = '0;
      if (wr_go) begin
         unique case (paddr)
            `AICF_OFF_CTRL: ctrl_nxt = pwdata[`AICF_CTRL_W-1:0];
            `AICF_OFF_ALM_EN: alm_en_nxt = pwdata[`AICF_ALM_W-1:0];
            `AICF_OFF_FILTER: filter_nxt = pwdata[15:0];
            `AICF_OFF_SIG_LO: pts_nxt.sig_lo = pwdata;
            `AICF_OFF_SIG_HI: pts_nxt.sig_hi = pwdata;
            `AICF_OFF_ENG_LO: pts_nxt.eng_lo = pwdata;
            `AICF_OFF_ENG_HI: pts_nxt.eng_hi = pwdata;
            `AICF_OFF_UNLATCH: unlatch_w = pwdata[`AICF_ALM_W-1:0];
            `AICF_OFF_IRQ_EN: irq_en_nxt = pwdata[`AICF_IRQ_W-1:0];
            `AICF_OFF_IRQ_CLR: irq_clr_w = pwdata[`AICF_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `AICF_CTRL_RST;
         alm_en_r <= '0;
         filter_r <= `AICF_FILTER_RST;
         pts_r <= {`AICF_SIG_LO_RST, `AICF_SIG_HI_RST, `AICF_ENG_LO_RST, `AICF_ENG_HI_RST};
         irq_en_r <= '0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         alm_en_r <= alm_en_nxt;
         filter_r <= filter_nxt;
         pts_r <= pts_nxt;
         irq_en_r <= irq_en_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Alarms, channel state and interrupts
   // ----------------------------------------------------------------
   logic fault_r, fault_nxt, led_r, led_nxt, owt_r, owt_nxt, ow_fault;
   logic irq_r, irq_nxt;
   aicf_alarm_type raw_alm, hold_mask;
   logic [`AICF_IRQ_W-1:0] irq_ev;

   always_comb begin
      raw_alm = {rate_cond, process_cond} & alm_en_r;
      hold_mask = {ctrl_r.rate_latch, {4{ctrl_r.proc_latch}}};
      // A new condition wins over an unlatch in the same cycle
      alarm_nxt = (alarm_r & hold_mask & alm_en_r & ~unlatch_w) | raw_alm;
      if (ctrl_r.alarm_mask) begin
         alarm_nxt = '0;
      end
      owt_nxt = ctrl_r.open_wire_en && !ctrl_r.off;
      ow_fault = owt_r && open_wire_detect;
      fault_nxt = ctrl_r.off || ow_fault;
      led_nxt = !ctrl_r.off;
      irq_ev = {scaled_nxt.valid, ow_fault && !fault_r, alarm_nxt & ~alarm_r};
      irq_stat_nxt = (irq_stat_r & ~irq_clr_w) | irq_ev;
      irq_nxt = |(irq_stat_nxt & irq_en_r);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_r <= '0;
         owt_r <= 1'b0;
         fault_r <= 1'b0;
         led_r <= 1'b0;
         irq_stat_r <= '0;
         irq_r <= 1'b0;
      end else begin
         alarm_r <= alarm_nxt;
         owt_r <= owt_nxt;
         fault_r <= fault_nxt;
         led_r <= led_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Filter and scaling
   // ----------------------------------------------------------------
   logic [31:0] tick_cnt_r, tick_cnt_nxt;
   logic tick_r, tick_nxt;
   aicf_sample_type filt;
   logic signed [32:0] dx, dy, ds;
   logic signed [65:0] prod, quot;

   always_comb begin
      tick_nxt = (tick_cnt_r == 32'(MS_CYCLES - 1));
      tick_cnt_nxt = tick_nxt ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
      dx = {filt.data[31], filt.data} - {pts_r.sig_lo[31], pts_r.sig_lo};
      dy = {pts_r.eng_hi[31], pts_r.eng_hi} - {pts_r.eng_lo[31], pts_r.eng_lo};
      ds = {pts_r.sig_hi[31], pts_r.sig_hi} - {pts_r.sig_lo[31], pts_r.sig_lo};
      prod = dx * dy;
      quot = (ds == 33'sh0) ? 66'sh0 : prod / $signed({{33{ds[32]}}, ds});
      scaled_nxt.valid = filt.valid;
      scaled_nxt.data = filt.valid ? pts_r.eng_lo + quot[31:0] : scaled_r.data;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b0;
         scaled_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         tick_r <= tick_nxt;
         scaled_r <= scaled_nxt;
      end
   end

   aicf_lag_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .smp(sample_in),
      .tau_ms(filter_r),
      .ms_tick(tick_r),
      .filt(filt)
   );

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign scaled_out = scaled_r;
   assign alarm_out = alarm_r;
   assign chan_fault = fault_r;
   assign status_led_on = led_r;
   assign open_wire_test_en = owt_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_proc_held;
      alarm_r[0] && ctrl_r.proc_latch && alm_en_r[0] && !ctrl_r.alarm_mask && !unlatch_w[0];
   endsequence

   chk_mask_all_off: assert property (ctrl_r.alarm_mask |=> alarm_r == '0)
      else $error("alarm active while channel alarms masked");
   chk_alarm_needs_en: assert property ((alarm_r & ~$past(alm_en_r)) == '0)
      else $error("alarm active without its enable");
   chk_proc_latch_hold: assert property (s_proc_held |=> alarm_r[0])
      else $error("latched process alarm dropped without unlatch");
   chk_proc_no_latch: assert property (
      (!ctrl_r.proc_latch && !process_cond[0]) |=> !alarm_r[0])
      else $error("process alarm held with latching off");
   chk_rate_follow: assert property (
      (!ctrl_r.rate_latch && !ctrl_r.alarm_mask) |=> alarm_r[4] == $past(rate_cond && alm_en_r[4]))
      else $error("rate alarm did not follow its condition");
   chk_open_wire_gate: assert property (
      open_wire_test_en |-> $past(ctrl_r.open_wire_en && !ctrl_r.off))
      else $error("open-wire diagnostic ran while not enabled");
   chk_off_fault_led: assert property (ctrl_r.off |=> (chan_fault && !status_led_on))
      else $error("disabled channel did not show fault and dark indicator");
   chk_scale_low_pt: assert property (
      (filt.valid && filt.data == pts_r.sig_lo && pts_r.sig_hi != pts_r.sig_lo)
      |=> scaled_r.valid && scaled_r.data == $past(pts_r.eng_lo))
      else $error("low signal point did not scale to low output point");
   chk_scale_high_pt: assert property (
      (filt.valid && filt.data == pts_r.sig_hi && pts_r.sig_hi != pts_r.sig_lo)
      |=> scaled_r.data == $past(pts_r.eng_hi))
      else $error("high signal point did not scale to high output point");

   // ----------------------------------------------------------------
   // Checks of latching and alarm gating
   // ----------------------------------------------------------------
   sequence s_rate_held;
      alarm_r[4] && ctrl_r.rate_latch && alm_en_r[4] && !ctrl_r.alarm_mask && !unlatch_w[4];
   endsequence

   chk_rate_latch_hold: assert property (s_rate_held |=> alarm_r[4])
      else $error("latched rate alarm dropped without unlatch");
   chk_rate_unlatch: assert property (
      (alarm_r[4] && unlatch_w[4] && !rate_cond) |=> !alarm_r[4])
      else $error("rate alarm stayed after unlatch");
   chk_proc_unlatch: assert property (
      (alarm_r[3] && unlatch_w[3] && !process_cond[3]) |=> !alarm_r[3])
      else $error("process alarm stayed after unlatch");
   chk_proc_follow: assert property (
      (!ctrl_r.proc_latch && !ctrl_r.alarm_mask)
      |=> alarm_r[3:0] == $past(process_cond & alm_en_r[3:0]))
      else $error("unlatched process alarms did not follow their conditions");
   chk_en_none_quiet: assert property ((alm_en_r == '0) |=> alarm_r == '0)
      else $error("alarm active with every enable clear");

   // ----------------------------------------------------------------
   // Checks of channel state, filter and value
   // ----------------------------------------------------------------
   chk_led_on: assert property (!ctrl_r.off |=> status_led_on)
      else $error("enabled channel shows a dark indicator");
   chk_fault_clear: assert property (
      (!ctrl_r.off && !open_wire_test_en) |=> !chan_fault)
      else $error("fault flag set on a healthy enabled channel");
   chk_open_wire_run: assert property (
      (ctrl_r.open_wire_en && !ctrl_r.off) |=> open_wire_test_en)
      else $error("open-wire diagnostic not running while enabled");
   chk_off_no_diag: assert property (ctrl_r.off |=> !open_wire_test_en)
      else $error("open-wire diagnostic ran on a disabled channel");
   chk_filter_hold: assert property (
      (filter_r != 16'h0000 && !tick_r) |=> $stable(filt.data))
      else $error("lag filter output moved between millisecond ticks");
   chk_bypass_latency: assert property (
      (filter_r == 16'h0000 && sample_in.valid) |-> ##2 scaled_r.valid)
      else $error("bypassed sample did not reach the scaled value in two cycles");
   chk_value_hold: assert property (!filt.valid |=> $stable(scaled_r.data))
      else $error("scaled value changed without a new sample");
endmodule

// ### verif/aicf_ctrl_model.sv
// Controller model: APB master that writes the channel settings
`timescale 1ns/1ps
`include "aicf_regs.svh"
module aicf_ctrl_model (
   input wire logic pclk, // Clock
   output logic psel, // APB select
   output logic penable, // APB enable
   output logic pwrite, // APB write
   output logic [7:0] paddr, // APB address
   output logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   output logic hung // Set when a transfer never got ready
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hFF;
      pwdata = 32'h0;
      hung = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // Set at once so the caller sees the timeout in this same time step
      if (pready !== 1'b1) hung = 1'b1;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released bus shows the inverse so stale values cannot pass
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   // Writes the low and high signal points, then the low and high output points
   task automatic points(input logic [31:0] lo, hi, el, eh);
      logic [31:0] q;
      logic e;
      xfer(1'b1, `AICF_OFF_SIG_LO, lo, q, e);
      xfer(1'b1, `AICF_OFF_SIG_HI, hi, q, e);
      xfer(1'b1, `AICF_OFF_ENG_LO, el, q, e);
      xfer(1'b1, `AICF_OFF_ENG_HI, eh, q, e);
   endtask
endmodule

// ### verif/tb_aicf_channel.sv
// Self-checking testbench of the channel block
`timescale 1ns/1ps
`include "aicf_regs.svh"
module tb_aicf_channel;
   import aicf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, lfsr_r;
   aicf_sample_type sample_in, scaled_out;
   logic [3:0] process_cond;
   logic rate_cond, open_wire_detect, chan_fault, status_led_on, open_wire_test_en, irq, e;
   aicf_alarm_type alarm_out;
   logic signed [31:0] d0, d1, y;
   int fail_count, checks;
   aicf_channel #(.MS_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_in(sample_in), .process_cond(process_cond),
      .rate_cond(rate_cond), .open_wire_detect(open_wire_detect), .scaled_out(scaled_out),
      .alarm_out(alarm_out), .chan_fault(chan_fault), .status_led_on(status_led_on),
      .open_wire_test_en(open_wire_test_en), .irq(irq));
   aicf_ctrl_model ctl_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hung(hung));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic signed [31:0] scale(input logic signed [31:0] x, lo, hi, el, eh);
      longint t;
      t = (longint'(x) - lo) * (longint'(eh) - el) / (longint'(hi) - lo);
      return 32'(el + t);
   endfunction
   task automatic results();
      if (hung === 1'b1) fail_count++;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bad(input string m);
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic cmp_w(input logic [31:0] g, x, input string m);
      checks++;
      if (g !== x) bad(m);
   endtask
   task automatic cmp_b(input logic g, x, input string m);
      checks++;
      if (g !== x) bad(m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ctl_u.xfer(1'b1, a, d, q, e);
      if (hung === 1'b1) begin
         bad("apb timeout");
         results();
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask
   task automatic conds(input logic [3:0] c, input logic r);
      @(posedge pclk);
      process_cond <= c;
      rate_cond <= r;
      settle();
   endtask
   task automatic send(input logic signed [31:0] d);
      @(posedge pclk);
      sample_in <= '{valid: 1'b1, data: d};
      @(posedge pclk);
      sample_in <= '{valid: 1'b0, data: ~d};
   endtask
   // Waits for a new value that differs from skip
   task automatic wait_val(input logic signed [31:0] skip, output logic signed [31:0] v);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge pclk);
         if (scaled_out.valid === 1'b1 && scaled_out.data !== skip) break;
      end
      if (n == 300) begin
         bad("no scaled value");
         results();
      end
      v = scaled_out.data;
   endtask
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      sample_in = '0;
      process_cond = 4'h0;
      rate_cond = 1'b0;
      open_wire_detect = 1'b0;
      fail_count = 0;
      checks = 0;
      lfsr_r = 32'h0DE784AA;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      ctl_u.xfer(1'b0, `AICF_OFF_CTRL, 32'h0, q, e);
      cmp_w(q, 32'h1, "ctrl reset");
      ctl_u.xfer(1'b0, `AICF_OFF_SIG_HI, 32'h0, q, e);
      cmp_w(q, 32'h4E20, "high point reset");
      ctl_u.xfer(1'b0, 8'hFC, 32'h0, q, e);
      cmp_b(e, 1'b1, "unmapped error");
      cmp_b(status_led_on, 1'b1, "led reset");
      cmp_b(open_wire_test_en, 1'b0, "diag reset");
      $display("test reset done");
      wr(`AICF_OFF_ALM_EN, 32'h1F);
      conds(4'hF, 1'b1);
      cmp_w(alarm_out, 32'h0, "masked alarms");
      wr(`AICF_OFF_CTRL, 32'h0);
      wr(`AICF_OFF_ALM_EN, 32'h01);
      settle();
      cmp_w(alarm_out, 32'h01, "only low-low enabled");
      wr(`AICF_OFF_ALM_EN, 32'h1F);
      conds(4'h0, 1'b0);
      cmp_w(alarm_out, 32'h0, "no latch follows");
      wr(`AICF_OFF_CTRL, 32'h6);
      conds(4'hF, 1'b1);
      conds(4'h0, 1'b0);
      cmp_w(alarm_out, 32'h1F, "latched alarms held");
      ctl_u.xfer(1'b0, `AICF_OFF_ALM_STAT, 32'h0, q, e);
      cmp_w(q, 32'h1F, "alarm status read");
      wr(`AICF_OFF_UNLATCH, 32'h1F);
      settle();
      cmp_w(alarm_out, 32'h0, "unlatched");
      $display("test alarms done");
      wr(`AICF_OFF_IRQ_CLR, 32'h7F);
      wr(`AICF_OFF_IRQ_EN, 32'h40);
      send(32'sd7);
      settle();
      cmp_b(irq, 1'b1, "value irq");
      ctl_u.xfer(1'b0, `AICF_OFF_IRQ_STAT, 32'h0, q, e);
      cmp_w(q, 32'h40, "irq status read");
      wr(`AICF_OFF_IRQ_CLR, 32'h40);
      settle();
      cmp_b(irq, 1'b0, "irq cleared");
      wr(`AICF_OFF_IRQ_EN, 32'h0);
      send(32'sd9);
      settle();
      cmp_b(irq, 1'b0, "irq masked");
      $display("test irq done");
      wr(`AICF_OFF_CTRL, 32'h8);
      open_wire_detect <= 1'b1;
      settle();
      cmp_b(open_wire_test_en, 1'b1, "diag on");
      cmp_b(chan_fault, 1'b1, "open wire fault");
      wr(`AICF_OFF_CTRL, 32'h0);
      settle();
      cmp_b(chan_fault, 1'b0, "diag off no fault");
      wr(`AICF_OFF_CTRL, 32'h10);
      settle();
      cmp_b(status_led_on, 1'b0, "off led dark");
      cmp_b(chan_fault, 1'b1, "off fault");
      wr(`AICF_OFF_CTRL, 32'h0);
      $display("test channel done");
      ctl_u.points(32'd1000, 32'd5000, -32'sd200, 32'sd1800);
      for (int i = 0; i < 8; i++) begin
         lfsr_r = lfsr(lfsr_r);
         d0 = (i == 0) ? 32'sd1000 : (i == 1) ? 32'sd5000 : 32'(signed'(lfsr_r[15:0]));
         send(d0);
         wait_val(32'sh7FFFFFFF, y);
         cmp_w(y, scale(d0, 1000, 5000, -200, 1800), "scaled value");
      end
      ctl_u.xfer(1'b0, `AICF_OFF_VALUE, 32'h0, q, e);
      cmp_w(q, scale(d0, 1000, 5000, -200, 1800), "value register");
      $display("test scaling done");
      ctl_u.points(32'd0, 32'h4E20, 32'd0, 32'h4E20);
      d0 = 32'sd100;
      d1 = 32'sd4100;
      send(d0);
      wait_val(32'sh7FFFFFFF, y);
      wr(`AICF_OFF_FILTER, 32'h1);
      send(d1);
      wait_val(d0, y);
      cmp_w(y, d0 + (d1 - d0) / 2, "lag step");
      $display("test filter done");
      results();
   end
endmodule
